// File: verilog/aei_pkg.sv
package aei_pkg;

    localparam int AEI_ADDR_W = 8;
    localparam int AEI_DATA_W = 32;
    localparam int AEI_REG_W  = 8;

    // Register indices, byte address is index times four
    localparam logic [5:0] AEI_IDX_CTRL    = 6'h00;
    localparam logic [5:0] AEI_IDX_ERR_EN  = 6'h06;
    localparam logic [5:0] AEI_IDX_EVT_EN  = 6'h07;
    localparam logic [5:0] AEI_IDX_ERR_FLG = 6'h08;
    localparam logic [5:0] AEI_IDX_EVT_STS = 6'h0c;

    // Error enable and flag bit positions
    localparam int AEI_B_BAD_ACCESS = 7;
    localparam int AEI_B_BAD_CMD    = 6;
    localparam int AEI_B_LIST_END   = 5;
    localparam int AEI_B_TRIGGER    = 3;
    localparam int AEI_B_RESTART    = 2;
    localparam int AEI_B_LOAD_OK    = 1;

    // Event enable and status bit positions
    localparam int AEI_B_ABORT_DONE = 7;
    localparam int AEI_B_OVERRUN    = 6;

    // Control register bit positions
    localparam int AEI_C_ENABLE  = 0;
    localparam int AEI_C_SOFT    = 1;
    localparam int AEI_C_RESTART = 2;
    localparam int AEI_C_HALTED  = 3;

    localparam logic [7:0] AEI_ERR_IMPL_M = 8'hee;
    localparam logic [7:0] AEI_ERR_SEV_M  = 8'he8;
    localparam logic [7:0] AEI_ERR_W1C_M  = 8'h06;
    localparam logic [7:0] AEI_EVT_IMPL_M = 8'hc0;
    localparam logic [7:0] AEI_REG_RST    = 8'h00;

    localparam logic [1:0] AEI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] AEI_RESP_SLVERR = 2'h2;

    // Events from the sequencer, all one-cycle pulses but load_ok
    typedef struct packed {
        logic store_bad_access;
        logic fetch_outside_mem;
        logic cmd_reserved_bits;
        logic reserved_resolution;
        logic list_end_missing;
        logic trigger_fault;
        logic trigger;
        logic restart;
        logic load_ok;
        logic eol_done;
        logic abort;
        logic abort_done;
        logic overrun;
    } aei_seq_ev_t;

    typedef struct packed {
        logic conv_enable;
        logic restart_mode;
        logic soft_reset;
        logic conv_run;
        logic halted;
    } aei_ctl_out_t;

endpackage

// File: verilog/aei_error_irq.sv
// Operation
// R1: Error enable bits 7,6,5 gate bad access, bad command, missing end errors.
// R2: Error enable bits 3,2,1 gate trigger, restart request, load-ok errors.
// R3: Event enable bit 7 gates the abort-done interrupt.
// R4: Event enable bit 6 gates the completion-flag overrun interrupt.
// R5: Any severe error flag stops the converter.
// R6: Soft reset clears all four severe flags so operation resumes.
// R7: Restart request and load-ok flags never stop the converter.
// R8: Restart request and load-ok flags clear on write one or soft reset.
// R9: All error flags held clear while the converter is disabled.
// R10: Writing zero keeps a flag; writing one never sets one.
// R11: Severe flags ignore software writes to the flag register.
// R12: Flag 7 sets on bad result store or command fetch outside memory.
// R13: Flag 6 sets on reserved command bits or reserved resolution code.
// R14: Flag 5 sets when the running list lacks an end command.
// R15: Both enable registers readable and writable at any time.
// R16: Flag 3 sets when a trigger arrives during a running sequence.
// R17: Flag 1 sets in restart mode on restart without load-ok; the code sets it only if a restart was already seen since enable or soft reset.
// R18: Flag 2 sets on restart between trigger and end or abort.
// R19: Interrupt asserted while any flag and its enable are both set.
`timescale 1ns/100ps
module aei_error_irq
    import aei_pkg::*;
#(
    parameter int ADDR_W = AEI_ADDR_W
)(
    input  logic              i_mclk,
    input  logic              i_rst,
    input  logic [ADDR_W-1:0] i_s_awaddr,
    input  logic              i_s_awvalid,
    output logic              o_s_awready,
    input  logic [31:0]       i_s_wdata,
    input  logic [3:0]        i_s_wstrb,
    input  logic              i_s_wvalid,
    output logic              o_s_wready,
    output logic [1:0]        o_s_bresp,
    output logic              o_s_bvalid,
    input  logic              i_s_bready,
    input  logic [ADDR_W-1:0] i_s_araddr,
    input  logic              i_s_arvalid,
    output logic              o_s_arready,
    output logic [31:0]       o_s_rdata,
    output logic [1:0]        o_s_rresp,
    output logic              o_s_rvalid,
    input  logic              i_s_rready,
    input  aei_seq_ev_t       i_seq_ev,
    output aei_ctl_out_t      o_ctl,
    output logic              o_irq
);

    localparam int IW = ADDR_W - 2;

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              wr_fire;
    logic              wr_hit;
    logic [IW-1:0]     wr_idx;
    logic              sel_ctrl;
    logic              sel_err_en;
    logic              sel_evt_en;
    logic              sel_err_flg;
    logic              sel_evt_sts;
    logic [7:0]        wbyte;
    logic              ctrl_enable;
    logic              ctrl_restart_mode;
    logic              soft_rst;
    logic              soft_rst_q;
    logic [7:0]        err_en;
    logic [7:0]        evt_en;
    logic [7:0]        err_flags;
    logic [7:0]        next_err_flags;
    logic [7:0]        err_set;
    logic [7:0]        evt_sts;
    logic [7:0]        next_evt_sts;
    logic [7:0]        evt_set;
    logic              seq_active;
    logic              restart_seen;
    logic              halted;
    logic              seq_end;

    function automatic logic is_mapped(input logic [IW-1:0] idx);
        is_mapped = (idx == IW'(AEI_IDX_CTRL))    ||
                    (idx == IW'(AEI_IDX_ERR_EN))  ||
                    (idx == IW'(AEI_IDX_EVT_EN))  ||
                    (idx == IW'(AEI_IDX_ERR_FLG)) ||
                    (idx == IW'(AEI_IDX_EVT_STS));
    endfunction

    // Write channel capture
    assign o_s_awready = ~aw_held & ~o_s_bvalid;
    assign o_s_wready  = ~w_held & ~o_s_bvalid;
    assign wr_fire     = aw_held & w_held & ~o_s_bvalid;
    assign wr_idx      = aw_addr[ADDR_W-1:2];
    assign wr_hit      = wr_fire & w_strb[0];
    assign wbyte       = w_data[7:0];
    assign sel_ctrl    = wr_hit & (wr_idx == IW'(AEI_IDX_CTRL));
    assign sel_err_en  = wr_hit & (wr_idx == IW'(AEI_IDX_ERR_EN));
    assign sel_evt_en  = wr_hit & (wr_idx == IW'(AEI_IDX_EVT_EN));
    assign sel_err_flg = wr_hit & (wr_idx == IW'(AEI_IDX_ERR_FLG));
    assign sel_evt_sts = wr_hit & (wr_idx == IW'(AEI_IDX_EVT_STS));

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (i_s_awvalid && o_s_awready) begin
            aw_held <= 1'b1;
            aw_addr <= i_s_awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (i_s_wvalid && o_s_wready) begin
            w_held <= 1'b1;
            w_data <= i_s_wdata;
            w_strb <= i_s_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_s_bvalid <= 1'b0;
            o_s_bresp  <= AEI_RESP_OKAY;
        end else if (wr_fire) begin
            o_s_bvalid <= 1'b1;
            o_s_bresp  <= is_mapped(wr_idx) ? AEI_RESP_OKAY
                                            : AEI_RESP_SLVERR;
        end else if (i_s_bready) begin
            o_s_bvalid <= 1'b0;
        end
    end

    // Read channel
    assign o_s_arready = ~o_s_rvalid;

    function automatic logic [7:0] rd_mux(input logic [IW-1:0] idx);
        rd_mux = AEI_REG_RST;
        if (idx == IW'(AEI_IDX_CTRL)) begin
            rd_mux[AEI_C_ENABLE]  = ctrl_enable;
            rd_mux[AEI_C_RESTART] = ctrl_restart_mode;
            rd_mux[AEI_C_HALTED]  = halted;
        end
        if (idx == IW'(AEI_IDX_ERR_EN)) begin
            rd_mux = err_en;
        end
        if (idx == IW'(AEI_IDX_EVT_EN)) begin
            rd_mux = evt_en;
        end
        if (idx == IW'(AEI_IDX_ERR_FLG)) begin
            rd_mux = err_flags;
        end
        if (idx == IW'(AEI_IDX_EVT_STS)) begin
            rd_mux = evt_sts;
        end
    endfunction

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_s_rvalid <= 1'b0;
            o_s_rdata  <= '0;
            o_s_rresp  <= AEI_RESP_OKAY;
        end else if (i_s_arvalid && o_s_arready) begin
            o_s_rvalid <= 1'b1;
            o_s_rdata  <= {24'h000000, rd_mux(i_s_araddr[ADDR_W-1:2])};
            o_s_rresp  <= is_mapped(i_s_araddr[ADDR_W-1:2])
                          ? AEI_RESP_OKAY : AEI_RESP_SLVERR;
        end else if (i_s_rready) begin
            o_s_rvalid <= 1'b0;
        end
    end

    // Control register, soft reset is a write pulse
    assign soft_rst = sel_ctrl & wbyte[AEI_C_SOFT];

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_enable       <= 1'b0;
            ctrl_restart_mode <= 1'b0;
            soft_rst_q        <= 1'b0;
        end else begin
            soft_rst_q <= soft_rst;
            if (sel_ctrl) begin
                ctrl_enable       <= wbyte[AEI_C_ENABLE];
                ctrl_restart_mode <= wbyte[AEI_C_RESTART];
            end
        end
    end

    // R1 R2 R15: error enable storage
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            err_en <= AEI_REG_RST;
        end else if (sel_err_en) begin
            err_en <= wbyte & AEI_ERR_IMPL_M;
        end
    end

    // R3 R4 R15: event enable storage
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            evt_en <= AEI_REG_RST;
        end else if (sel_evt_en) begin
            evt_en <= wbyte & AEI_EVT_IMPL_M;
        end
    end

    property p_enable_rw;
        sel_err_en |=> err_en == ($past(wbyte) & AEI_ERR_IMPL_M);
    endproperty
    a_enable_rw: assert property (p_enable_rw) // R15
        else $error("error enable did not take write");

    // Sequence tracking for flow errors
    assign seq_end = i_seq_ev.eol_done | i_seq_ev.abort;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            seq_active <= 1'b0;
        end else if (!ctrl_enable || soft_rst || seq_end) begin
            seq_active <= 1'b0;
        end else if (i_seq_ev.trigger) begin
            seq_active <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            restart_seen <= 1'b0;
        end else if (!ctrl_enable || soft_rst) begin
            restart_seen <= 1'b0;
        end else if (i_seq_ev.restart) begin
            restart_seen <= 1'b1;
        end
    end

    // Hardware set terms
    always_comb begin
        err_set = AEI_REG_RST;
        // R12: bad access sources
        err_set[AEI_B_BAD_ACCESS] = i_seq_ev.store_bad_access |
                                    i_seq_ev.fetch_outside_mem;
        // R13: bad command sources
        err_set[AEI_B_BAD_CMD] = i_seq_ev.cmd_reserved_bits |
                                 i_seq_ev.reserved_resolution;
        // R14: missing end command
        err_set[AEI_B_LIST_END] = i_seq_ev.list_end_missing;
        // R16: trigger while running
        err_set[AEI_B_TRIGGER] = i_seq_ev.trigger_fault |
                                 (i_seq_ev.trigger & seq_active &
                                  ~seq_end);
        // R18: restart inside sequence
        err_set[AEI_B_RESTART] = i_seq_ev.restart & seq_active &
                                 ~seq_end;
        // R17: restart without load-ok
        err_set[AEI_B_LOAD_OK] = ctrl_restart_mode & restart_seen &
                                 i_seq_ev.restart &
                                 ~i_seq_ev.load_ok & ~i_seq_ev.abort;
    end

    // Error flag update, set wins over clear
    always_comb begin
        next_err_flags = err_flags;
        // R6 R8: soft reset clears
        if (soft_rst) begin
            next_err_flags = AEI_REG_RST;
        // R8 R10 R11: write one clears two bits only
        end else if (sel_err_flg) begin
            next_err_flags = err_flags & ~(wbyte & AEI_ERR_W1C_M);
        end
        next_err_flags = next_err_flags | err_set;
        // R9: disable holds all clear
        if (!ctrl_enable) begin
            next_err_flags = AEI_REG_RST;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            err_flags <= AEI_REG_RST;
        end else begin
            err_flags <= next_err_flags;
        end
    end

    property p_disable_clear;
        !ctrl_enable |=> err_flags == 8'h00;
    endproperty
    a_disable_clear: assert property (p_disable_clear) // R9
        else $error("flags not clear while disabled");
    property p_soft_clear;
        soft_rst && err_set == 8'h00 |=> (err_flags & AEI_ERR_SEV_M) == 8'h00;
    endproperty
    a_soft_clear: assert property (p_soft_clear) // R6
        else $error("severe flag survived soft reset");
    property p_w1c;
        sel_err_flg && wbyte[AEI_B_LOAD_OK] && !err_set[AEI_B_LOAD_OK]
            |=> !err_flags[AEI_B_LOAD_OK];
    endproperty
    a_w1c: assert property (p_w1c) // R8
        else $error("load-ok flag not cleared by write one");
    property p_no_sw_set;
        err_set == 8'h00 |=> (err_flags & ~$past(err_flags)) == 8'h00;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) // R10
        else $error("flag set without hardware event");
    property p_sev_locked;
        sel_err_flg && !soft_rst && ctrl_enable
            |=> ($past(err_flags) & ~err_flags & AEI_ERR_SEV_M) == 8'h00;
    endproperty
    a_sev_locked: assert property (p_sev_locked) // R11
        else $error("severe flag cleared by software write");
    property p_bad_access;
        ctrl_enable && (i_seq_ev.store_bad_access ||
                        i_seq_ev.fetch_outside_mem)
            |=> err_flags[AEI_B_BAD_ACCESS];
    endproperty
    a_bad_access: assert property (p_bad_access) // R12
        else $error("bad access flag not set");
    property p_trigger_err;
        ctrl_enable && i_seq_ev.trigger && seq_active && !seq_end
            |=> err_flags[AEI_B_TRIGGER];
    endproperty
    a_trigger_err: assert property (p_trigger_err) // R16
        else $error("trigger error flag not set");
    property p_load_ok_mode;
        $rose(err_flags[AEI_B_LOAD_OK])
            |-> $past(ctrl_restart_mode) && $past(i_seq_ev.restart);
    endproperty
    a_load_ok_mode: assert property (p_load_ok_mode) // R17
        else $error("load-ok flag set outside restart mode");

    // Event status, write one to clear, set wins
    assign evt_set = {i_seq_ev.abort_done, i_seq_ev.overrun, 6'h00};

    always_comb begin
        next_evt_sts = evt_sts;
        if (sel_evt_sts) begin
            next_evt_sts = evt_sts & ~wbyte;
        end
        next_evt_sts = (next_evt_sts | evt_set) & AEI_EVT_IMPL_M;
        if (!ctrl_enable) begin
            next_evt_sts = AEI_REG_RST;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            evt_sts <= AEI_REG_RST;
        end else begin
            evt_sts <= next_evt_sts;
        end
    end

    // R5 R7: only severe flags halt
    assign halted = |(err_flags & AEI_ERR_SEV_M);

    // R19: masked interrupt request
    assign o_irq = (|(err_flags & err_en)) | (|(evt_sts & evt_en));

    assign o_ctl.conv_enable  = ctrl_enable;
    assign o_ctl.restart_mode = ctrl_restart_mode;
    assign o_ctl.soft_reset   = soft_rst_q;
    assign o_ctl.halted       = halted;
    assign o_ctl.conv_run     = ctrl_enable & ~halted;

    property p_halt;
        ctrl_enable && err_set[AEI_B_BAD_CMD] |=> !o_ctl.conv_run;
    endproperty
    a_halt: assert property (p_halt) // R5
        else $error("converter runs with severe error");

    property p_keep_running;
        ctrl_enable && !halted && (err_set & AEI_ERR_SEV_M) == 8'h00
            && !sel_ctrl |=> o_ctl.conv_run;
    endproperty
    a_keep_running: assert property (p_keep_running) // R7
        else $error("converter stopped by non-severe flag");

    property p_irq;
        ctrl_enable && err_en[AEI_B_TRIGGER] && err_set[AEI_B_TRIGGER]
            && !sel_err_en |=> o_irq;
    endproperty
    a_irq: assert property (p_irq) // R19
        else $error("enabled error gave no interrupt");

endmodule

// File: tb/tb.sv
`timescale 1ns/100ps
module tb;
    import aei_pkg::*;

    localparam logic [7:0] A_CTL = {AEI_IDX_CTRL, 2'b00};
    localparam logic [7:0] A_EEN = {AEI_IDX_ERR_EN, 2'b00};
    localparam logic [7:0] A_VEN = {AEI_IDX_EVT_EN, 2'b00};
    localparam logic [7:0] A_FLG = {AEI_IDX_ERR_FLG, 2'b00};
    localparam logic [7:0] A_STS = {AEI_IDX_EVT_STS, 2'b00};

    logic         i_mclk;
    logic         i_rst;
    logic [7:0]   awaddr;
    logic         awvalid;
    logic         awready;
    logic [31:0]  wdata;
    logic [3:0]   wstrb;
    logic         wvalid;
    logic         wready;
    logic [1:0]   bresp;
    logic         bvalid;
    logic         bready;
    logic [7:0]   araddr;
    logic         arvalid;
    logic         arready;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         rvalid;
    logic         rready;
    aei_seq_ev_t  ev;
    aei_ctl_out_t ctl;
    logic         irq;
    int           err_total;
    int           tests_run;
    logic [31:0]  rd_val;
    logic [1:0]   rsp;
    int           ev_idx [6] = '{12, 11, 10, 9, 8, 7};
    int           flg_bit [6] = '{7, 7, 6, 6, 5, 3};

    aei_error_irq dut (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_s_awaddr  (awaddr),
        .i_s_awvalid (awvalid),
        .o_s_awready (awready),
        .i_s_wdata   (wdata),
        .i_s_wstrb   (wstrb),
        .i_s_wvalid  (wvalid),
        .o_s_wready  (wready),
        .o_s_bresp   (bresp),
        .o_s_bvalid  (bvalid),
        .i_s_bready  (bready),
        .i_s_araddr  (araddr),
        .i_s_arvalid (arvalid),
        .o_s_arready (arready),
        .o_s_rdata   (rdata),
        .o_s_rresp   (rresp),
        .o_s_rvalid  (rvalid),
        .i_s_rready  (rready),
        .i_seq_ev    (ev),
        .o_ctl       (ctl),
        .o_irq       (irq)
    );

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic hang(input string nm);
        err_total++;
        $display("MISMATCH %s expected answer seen none", nm);
        summarize();
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        bit aw_done;
        bit w_done;
        bit b_done;
        int n;
        aw_done = 0;
        w_done = 0;
        b_done = 0;
        @(posedge i_mclk);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50 && !b_done; n++) begin
            @(posedge i_mclk);
            if (!aw_done && awready) begin
                aw_done = 1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1;
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                b_done = 1;
                rsp = bresp;
                bready <= 1'b0;
            end
        end
        if (!b_done) hang("write response");
    endtask

    task automatic axi_rd(input logic [7:0] a);
        bit ar_done;
        bit r_done;
        int n;
        ar_done = 0;
        r_done = 0;
        @(posedge i_mclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50 && !r_done; n++) begin
            @(posedge i_mclk);
            if (!ar_done && arready) begin
                ar_done = 1;
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                r_done = 1;
                rd_val = rdata;
                rsp = rresp;
                rready <= 1'b0;
            end
        end
        if (!r_done) hang("read data");
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        axi_rd(a);
        chk(nm, rd_val, exp);
        chk({nm, " resp"}, {30'h0, rsp}, {30'h0, AEI_RESP_OKAY});
    endtask

    task automatic pulse(input int idx);
        @(posedge i_mclk);
        ev <= aei_seq_ev_t'(13'(1) << idx);
        @(posedge i_mclk);
        ev <= '0;
        repeat (2) @(posedge i_mclk);
    endtask

    initial begin
        err_total = 0;
        tests_run = 0;
        i_rst = 1'b1;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        ev = '0;
        repeat (20) @(posedge i_mclk);
        i_rst <= 1'b0;

        rd_chk("err_en reset", A_EEN, 32'h0);
        chk("irq reset", {31'h0, irq}, 32'h0);
        rd_chk("evt_en reset", A_VEN, 32'h0);
        axi_wr(A_EEN, 8'hff);
        chk("wr resp", {30'h0, rsp}, {30'h0, AEI_RESP_OKAY});
        rd_chk("err_en bits", A_EEN, 32'hee);
        axi_wr(A_VEN, 8'hff);
        rd_chk("evt_en bits", A_VEN, 32'hc0);
        axi_rd(8'h44);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, AEI_RESP_SLVERR});
        chk("unmapped data", rd_val, 32'h0);
        axi_wr(8'h44, 8'hff);
        chk("unmapped wr", {30'h0, rsp}, {30'h0, AEI_RESP_SLVERR});
        $display("Test registers done");

        pulse(12);
        rd_chk("flags disabled", A_FLG, 32'h0);
        $display("Test disabled done");

        for (int i = 0; i < 6; i++) begin
            axi_wr(A_CTL, 8'h03);
            chk("soft pulse", {31'h0, ctl.soft_reset}, 32'h1);
            rd_chk("flags after soft", A_FLG, 32'h0);
            chk("run after soft", {31'h0, ctl.conv_run}, 32'h1);
            chk("soft pulse end", {31'h0, ctl.soft_reset}, 32'h0);
            pulse(ev_idx[i]);
            rd_chk("severe flag", A_FLG, 32'h1 << flg_bit[i]);
            chk("halted", {31'h0, ctl.halted}, 32'h1);
            chk("run stopped", {31'h0, ctl.conv_run}, 32'h0);
            chk("irq severe", {31'h0, irq}, 32'h1);
            axi_wr(A_FLG, 8'hff);
            rd_chk("severe no w1c", A_FLG, 32'h1 << flg_bit[i]);
        end
        axi_wr(A_EEN, 8'h17);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axi_wr(A_EEN, 8'hee);
        $display("Test severe done");

        axi_wr(A_CTL, 8'h03);
        pulse(6);
        pulse(5);
        rd_chk("restart flag", A_FLG, 32'h04);
        chk("run on restart err", {31'h0, ctl.conv_run}, 32'h1);
        chk("irq restart", {31'h0, irq}, 32'h1);
        axi_wr(A_FLG, 8'h00);
        rd_chk("w0 keeps", A_FLG, 32'h04);
        axi_wr(A_FLG, 8'h04);
        rd_chk("w1 clears", A_FLG, 32'h0);
        pulse(6);
        rd_chk("trigger while busy", A_FLG, 32'h08);
        $display("Test restart done");

        axi_wr(A_CTL, 8'h07);
        chk("restart mode out", {31'h0, ctl.restart_mode}, 32'h1);
        pulse(5);
        rd_chk("first restart", A_FLG, 32'h0);
        pulse(5);
        rd_chk("load ok flag", A_FLG, 32'h02);
        chk("run on load err", {31'h0, ctl.conv_run}, 32'h1);
        axi_wr(A_FLG, 8'h02);
        rd_chk("load ok clear", A_FLG, 32'h0);
        @(posedge i_mclk);
        ev <= aei_seq_ev_t'(13'h0030);
        @(posedge i_mclk);
        ev <= '0;
        rd_chk("restart with ok", A_FLG, 32'h0);
        pulse(5);
        rd_chk("load ok again", A_FLG, 32'h02);
        axi_wr(A_CTL, 8'h07);
        rd_chk("soft clears", A_FLG, 32'h0);
        $display("Test load ok done");

        axi_wr(A_EEN, 8'h00);
        axi_wr(A_VEN, 8'h80);
        pulse(1);
        rd_chk("abort done sts", A_STS, 32'h80);
        chk("irq abort", {31'h0, irq}, 32'h1);
        pulse(0);
        rd_chk("overrun sts", A_STS, 32'hc0);
        axi_wr(A_STS, 8'h80);
        chk("irq abort cleared", {31'h0, irq}, 32'h0);
        axi_wr(A_VEN, 8'h40);
        chk("irq overrun", {31'h0, irq}, 32'h1);
        pulse(12);
        axi_wr(A_CTL, 8'h00);
        rd_chk("disable flags", A_FLG, 32'h0);
        chk("disable irq", {31'h0, irq}, 32'h0);
        chk("disable out", {31'h0, ctl.conv_enable}, 32'h0);
        $display("Test events done");
        summarize();
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        hang("run time");
    end
endmodule
